// File: src/cbdp_pkg.sv
// shared constants and types for the local bus data and parity section
package cbdp_pkg;
  // =====================================================
  // widths
  localparam int CBDP_AW = 30;          // word address bits 31..2
  localparam int CBDP_UW = 28;          // upper address bits 31..4
  localparam int CBDP_DW = 32;          // data bus width
  localparam int CBDP_NB = 4;           // byte lanes
  // =====================================================
  // field positions
  localparam int CBDP_UPPER_LSB = 2;    // upper lines start at word index 2
  // =====================================================
  // reset values
  localparam logic [CBDP_NB-1:0] CBDP_BE_IDLE = 4'hF;  // all lanes off
  localparam logic CBDP_PARITY_CHECK_STATUS_N_IDLE = 1'h1;              // status inactive
  // =====================================================
  // timing counts, in clocks
  localparam int CBDP_WR_DRIVE_CLK = 1; // data driven from second clock
  // cycle state of the device end
  typedef enum logic [1:0] {CBDP_IDLE, CBDP_T1, CBDP_T2} cbdp_state_t;

  // even parity per byte: ones in byte plus bit is even
  function automatic logic [CBDP_NB-1:0] cbdp_parity(input logic [CBDP_DW-1:0] d);
    logic [CBDP_NB-1:0] p;
    p = '0;
    for (int i = 0; i < CBDP_NB; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction
endpackage

// File: src/cbdp_if.sv
// pin-level carrier joining the device end and the system end
`timescale 1ns/1ns
`default_nettype none
interface cbdp_if;
  import cbdp_pkg::*;
  // =====================================================
  // device- and system-driven pins with enables
  logic [CBDP_AW-1:0] dev_addr;          // word_address_lines from device
  logic addr_oe;                         // device drives address
  logic [CBDP_UW-1:0] sys_inv_addr;      // upper_address_lines from system
  logic sys_inv_oe;                      // system drives invalidation address
  logic [CBDP_NB-1:0] byte_lane_enables_n;
  logic be_oe;                           // device drives byte enables
  logic address_strobe_n;                // cycle start
  logic write_cycle;                     // 1 write, 0 read, valid with strobe
  logic [CBDP_DW-1:0] dev_data;          // write data_lines
  logic [CBDP_NB-1:0] dev_par;           // write byte_parity_lines
  logic dev_data_oe;                     // device drives data and parity
  logic [CBDP_DW-1:0] sys_data;          // read data from system
  logic [CBDP_NB-1:0] sys_par;           // read parity from system
  logic sys_data_oe;                     // system drives data and parity
  logic ready_n;                         // ready, active low
  logic [CBDP_NB-1:0] size_mask;         // lanes the bus size keeps live
  logic parity_check_status_n;           // low flags read parity error
  modport device (
    output dev_addr, addr_oe, byte_lane_enables_n, be_oe, address_strobe_n,
    output write_cycle, dev_data, dev_par, dev_data_oe, parity_check_status_n,
    input sys_inv_addr, sys_inv_oe, sys_data, sys_par, sys_data_oe, ready_n,
    input size_mask
  );
  modport system (
    input dev_addr, addr_oe, byte_lane_enables_n, be_oe, address_strobe_n,
    input write_cycle, dev_data, dev_par, dev_data_oe, parity_check_status_n,
    output sys_inv_addr, sys_inv_oe, sys_data, sys_par, sys_data_oe, ready_n,
    output size_mask
  );
endinterface
`default_nettype wire

// File: src/cbdp_par_check.sv
// read parity checker for enabled byte lanes
`timescale 1ns/1ns
`default_nettype none
module cbdp_par_check
  import cbdp_pkg::*;
(
  input wire logic [cbdp_pkg::CBDP_DW-1:0] data,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] par,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] lane_on,
  output logic err
);
  // =====================================================
  // lane compare
  logic [CBDP_NB-1:0] bad; // per-lane mismatch
  genvar g;
  generate
    for (g = 0; g < CBDP_NB; g++) begin : lane
      assign bad[g] = lane_on[g] & (^{data[8*g +: 8], par[g]});
    end
  endgenerate
  assign err = |bad;
endmodule
`default_nettype wire

// File: src/cbdp_device.sv
// processor end: address, byte enables, write data, parity and check status
// Overview of operation
// - everything on the rising clock edge
// - word address plus byte enables select
// - upper lines take invalidation addresses
// - address floats in bus or address hold
// - active-low byte enables, float in bus hold only
// - system treats line fill as all bytes
// - enable n governs data byte n
// - bits 7..0 least significant byte
// - write data driven from second clock
// - one parity bit per written byte
// - system returns even parity on reads
// - parity never alters delivered data
// - active-high parity, driven like data
// - status in clock after ready
// - low status means parity error
// - check only lanes enabled twice
// - status valid one clock, else high
// - cycle definition valid with strobe
`timescale 1ns/1ns
`default_nettype none
module cbdp_device
  import cbdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  cbdp_if.device bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [cbdp_pkg::CBDP_AW-1:0] req_addr,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] req_be_n,
  input wire logic [cbdp_pkg::CBDP_DW-1:0] req_wdata,
  input wire logic bus_hold,
  input wire logic addr_hold,
  output logic req_busy,
  output logic rd_valid,
  output logic [cbdp_pkg::CBDP_DW-1:0] rd_data,
  output logic wr_done,
  output logic inv_valid,
  output logic [cbdp_pkg::CBDP_UW-1:0] inv_addr
);
  // =====================================================
  // state
  cbdp_state_t state_r;                  // cycle phase
  logic write_r;                         // current cycle direction
  logic [CBDP_NB-1:0] be_n_r;            // latched byte enables
  logic [CBDP_DW-1:0] wdata_r;           // latched write data
  logic rd_par_err;                      // checker result
  logic [CBDP_NB-1:0] live_lanes;        // lanes enabled by both
  logic ready;                           // ready seen this clock

  assign ready = ~bus.ready_n;
  // byte enables and bus size together
  assign live_lanes = ~be_n_r & bus.size_mask;

  // a new cycle starts only from idle with no hold in force;
  // sequencing, capture and pin logic share it so they never disagree
  function automatic logic start_ok(input cbdp_state_t st, input logic rq, input logic hold);
    return (st == CBDP_IDLE) && rq && !hold;
  endfunction

  // shared checker on raw sampled read data
  cbdp_par_check u_chk (
    .data(bus.sys_data),
    .par(bus.sys_par),
    .lane_on(live_lanes),
    .err(rd_par_err)
  );

  // =====================================================
  // cycle sequencing
  // hold blocks new cycles; a running cycle finishes first
  // rising edge of the one clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= CBDP_IDLE;
    end else if (clk_en) begin
      case (state_r)
        CBDP_IDLE: begin
          if (start_ok(state_r, req_valid, bus_hold || addr_hold)) begin
            state_r <= CBDP_T1;
          end
        end
        CBDP_T1: begin
          state_r <= CBDP_T2;
        end
        CBDP_T2: begin
          if (ready) begin
            state_r <= CBDP_IDLE;
          end
        end
        default: begin
          state_r <= CBDP_IDLE;
        end
      endcase
    end
  end

  // request capture, taken when the cycle starts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_r <= 1'h0;
      be_n_r <= CBDP_BE_IDLE;
      wdata_r <= 32'h0;
    end else if (clk_en && start_ok(state_r, req_valid, bus_hold || addr_hold)) begin
      write_r <= req_write;
      be_n_r <= req_be_n;
      wdata_r <= req_wdata;
    end
  end

  // =====================================================
  // address and byte enable pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus.dev_addr <= '0;
      bus.addr_oe <= 1'h0;
      bus.byte_lane_enables_n <= CBDP_BE_IDLE;
      bus.be_oe <= 1'h0;
      bus.address_strobe_n <= 1'h1;
      bus.write_cycle <= 1'h0;
    end else if (clk_en) begin
      bus.addr_oe <= !(bus_hold || addr_hold);
      // float byte enables in bus hold
      bus.be_oe <= !bus_hold;
      bus.address_strobe_n <= 1'h1;
      if (start_ok(state_r, req_valid, bus_hold || addr_hold)) begin
        bus.dev_addr <= req_addr;
        bus.byte_lane_enables_n <= req_be_n;
        bus.write_cycle <= req_write;
        bus.address_strobe_n <= 1'h0;
      end
    end
  end

  // =====================================================
  // write data and parity pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus.dev_data <= 32'h0;
      bus.dev_par <= 4'h0;
      bus.dev_data_oe <= 1'h0;
    end else if (clk_en) begin
      // enable from second clock until ready
      if (state_r == CBDP_T1 && write_r) begin
        bus.dev_data_oe <= 1'h1;
        bus.dev_data <= wdata_r;
        bus.dev_par <= cbdp_parity(wdata_r);
      end else if (state_r == CBDP_T2 && ready) begin
        bus.dev_data_oe <= 1'h0;
      end
    end
  end

  // =====================================================
  // read return and parity status
  // data goes to the core unchanged, status is advisory only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_valid <= 1'h0;
      rd_data <= 32'h0;
      wr_done <= 1'h0;
      bus.parity_check_status_n <= CBDP_PARITY_CHECK_STATUS_N_IDLE;
    end else if (clk_en) begin
      rd_valid <= 1'h0;
      wr_done <= 1'h0;
      // high except the clock after read data
      bus.parity_check_status_n <= CBDP_PARITY_CHECK_STATUS_N_IDLE;
      if (state_r == CBDP_T2 && ready) begin
        if (write_r) begin
          wr_done <= 1'h1;
        end else begin
          rd_valid <= 1'h1;
          rd_data <= bus.sys_data;
          // status next clock, low on error
          bus.parity_check_status_n <= ~rd_par_err;
        end
      end
    end
  end

  // =====================================================
  // invalidation address capture and busy flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inv_valid <= 1'h0;
      inv_addr <= '0;
      req_busy <= 1'h0;
    end else if (clk_en) begin
      // upper lines taken only when device floats them
      inv_valid <= bus.sys_inv_oe && !bus.addr_oe;
      inv_addr <= bus.sys_inv_addr;
      req_busy <= (state_r != CBDP_IDLE) || req_valid || bus_hold || addr_hold;
    end
  end
endmodule
`default_nettype wire

// File: src/cbdp_system.sv
// system end: returns read data with even parity, drives invalidations
`timescale 1ns/1ns
`default_nettype none
module cbdp_system
  import cbdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  cbdp_if.system bus,
  input wire logic [cbdp_pkg::CBDP_DW-1:0] rd_word,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] lane_size_mask,
  input wire logic inv_req,
  input wire logic [cbdp_pkg::CBDP_UW-1:0] inv_line,
  output logic [cbdp_pkg::CBDP_DW-1:0] wr_word,
  output logic [cbdp_pkg::CBDP_NB-1:0] wr_lanes,
  output logic wr_valid,
  output logic par_err_seen
);
  // =====================================================
  // cycle tracking
  logic active_r; // waiting one clock before ready
  logic write_r;  // direction of current cycle
  logic [CBDP_NB-1:0] lanes_r; // lanes enabled on this cycle

  // one wait state, then ready; data and parity driven together
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_r <= 1'h0;
      write_r <= 1'h0;
      lanes_r <= 4'h0;
      bus.ready_n <= 1'h1;
      bus.sys_data <= 32'h0;
      bus.sys_par <= 4'h0;
      bus.sys_data_oe <= 1'h0;
      bus.size_mask <= 4'hF;
    end else if (clk_en) begin
      bus.ready_n <= 1'h1;
      bus.sys_data_oe <= 1'h0;
      bus.size_mask <= lane_size_mask;
      if (!bus.address_strobe_n) begin
        active_r <= 1'h1;
        write_r <= bus.write_cycle;
        // a fill would count all lanes active
        lanes_r <= ~bus.byte_lane_enables_n;
      end else if (active_r) begin
        active_r <= 1'h0;
        bus.ready_n <= 1'h0;
        if (!write_r) begin
          bus.sys_data_oe <= 1'h1;
          bus.sys_data <= rd_word;
          // even parity, count of ones even
          bus.sys_par <= cbdp_parity(rd_word);
        end
      end
    end
  end

  // write capture and status watch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_word <= 32'h0;
      wr_lanes <= 4'h0;
      wr_valid <= 1'h0;
      par_err_seen <= 1'h0;
    end else if (clk_en) begin
      wr_valid <= 1'h0;
      // sampled on the rising edge with ready
      if (!bus.ready_n && write_r && bus.dev_data_oe) begin
        wr_valid <= 1'h1;
        wr_word <= bus.dev_data;
        wr_lanes <= lanes_r;
      end
      par_err_seen <= !bus.parity_check_status_n;
    end
  end

  // invalidation address drive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus.sys_inv_addr <= '0;
      bus.sys_inv_oe <= 1'h0;
    end else if (clk_en) begin
      bus.sys_inv_oe <= inv_req && !bus.addr_oe;
      bus.sys_inv_addr <= inv_line;
    end
  end
endmodule
`default_nettype wire

// File: test/cbdp_monitor.sv
// checker for the data, parity and status wires between the two ends
`timescale 1ns/1ns
`default_nettype none
module cbdp_monitor
  import cbdp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addr_oe,
  input wire logic sys_inv_oe,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] byte_lane_enables_n,
  input wire logic be_oe,
  input wire logic address_strobe_n,
  input wire logic write_cycle,
  input wire logic [cbdp_pkg::CBDP_DW-1:0] dev_data,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] dev_par,
  input wire logic dev_data_oe,
  input wire logic [cbdp_pkg::CBDP_DW-1:0] sys_data,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] sys_par,
  input wire logic sys_data_oe,
  input wire logic ready_n,
  input wire logic [cbdp_pkg::CBDP_NB-1:0] size_mask,
  input wire logic parity_check_status_n
);
  // ==========
  // helpers
  logic [CBDP_NB-1:0] be_q_r; // lanes caught at strobe
  logic wr_q_r; // direction caught at strobe
  logic rd_err; // an enabled live lane is odd
  // enables are only trusted at the strobe
  always_ff @(posedge sys_clk) begin
    if (!address_strobe_n) begin
      be_q_r <= byte_lane_enables_n;
      wr_q_r <= write_cycle;
    end
  end
  // own parity, kept apart from the design
  function automatic logic [3:0] epar(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction
  assign rd_err = |((epar(sys_data) ^ sys_par) & ~be_q_r & size_mask);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  sequence s_wr_start;
    !address_strobe_n && write_cycle;
  endsequence
  sequence s_wr_data;
    !dev_data_oe ##1 dev_data_oe;
  endsequence
  property p_wr_data; s_wr_start |-> s_wr_data; endproperty
  property p_wr_par; dev_data_oe |-> dev_par == epar(dev_data); endproperty
  // status must be high unless the last clock was a read ready; checked every clock
  property p_chk_after; ($past(ready_n) || wr_q_r) |-> parity_check_status_n; endproperty
  // back high two clocks after any ready, so a low status lasts one clock
  property p_chk_one; !ready_n |-> ##2 parity_check_status_n; endproperty
  property p_chk_val;
    !ready_n && !wr_q_r |=> parity_check_status_n != $past(rd_err);
  endproperty
  property p_strobe_pins; !address_strobe_n |-> addr_oe && be_oe; endproperty
  property p_strobe_pulse; !address_strobe_n |=> address_strobe_n; endproperty
  property p_inv_turn; sys_inv_oe |-> !addr_oe; endproperty
  property p_data_turn; dev_data_oe |-> !sys_data_oe; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data timing wrong");
  a_wr_par: assert property (p_wr_par) else $error("write parity wrong");
  a_chk_after: assert property (p_chk_after) else $error("status low off time");
  a_chk_one: assert property (p_chk_one) else $error("status low too long");
  a_chk_val: assert property (p_chk_val) else $error("status value wrong");
  a_strobe_pins: assert property (p_strobe_pins) else $error("pins float at strobe");
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  a_inv_turn: assert property (p_inv_turn) else $error("address clash");
  a_data_turn: assert property (p_data_turn) else $error("data clash");
endmodule
`default_nettype wire

// File: test/cpu_bus_data_parity_tb_top.sv
// testbench joining both ends, plus a device end facing a scripted faulty system
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module cpu_bus_data_parity_tb_top;
  import cbdp_pkg::*;
  logic sys_clk = 0, rst = 1, rv = 0, rv2 = 0, rw = 0, bh = 0, ah = 0, iq = 0;
  logic [CBDP_AW-1:0] ra = '0;
  logic [CBDP_NB-1:0] rbe = 4'hF, lsm = 4'hF, wrl;
  logic [CBDP_DW-1:0] rwd = '0, rdw = '0, rdd, rdd2, wrw;
  logic [CBDP_UW-1:0] il = '0, inva;
  logic busy, rdv, rdv2, wrd, invv, wrv, pes;
  int n_fail = 0, tests_run = 0;
  cbdp_if bus();
  cbdp_if bus2(); // far side scripted here
  // free running clock
  always #50 sys_clk = ~sys_clk;
  cbdp_device cbdp_device_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .bus(bus),
    .req_valid(rv), .req_write(rw), .req_addr(ra), .req_be_n(rbe), .req_wdata(rwd),
    .bus_hold(bh), .addr_hold(ah), .req_busy(busy), .rd_valid(rdv), .rd_data(rdd),
    .wr_done(wrd), .inv_valid(invv), .inv_addr(inva));
  cbdp_device cbdp_device_bad_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .bus(bus2),
    .req_valid(rv2), .req_write(rw), .req_addr(ra), .req_be_n(rbe), .req_wdata(rwd),
    .bus_hold(bh), .addr_hold(ah), .req_busy(), .rd_valid(rdv2), .rd_data(rdd2),
    .wr_done(), .inv_valid(), .inv_addr());
  cbdp_system cbdp_system_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .bus(bus),
    .rd_word(rdw), .lane_size_mask(lsm), .inv_req(iq), .inv_line(il), .wr_word(wrw),
    .wr_lanes(wrl), .wr_valid(wrv), .par_err_seen(pes));
  cbdp_monitor cbdp_monitor_i (.sys_clk(sys_clk), .rst(rst), .addr_oe(bus.addr_oe),
    .sys_inv_oe(bus.sys_inv_oe), .byte_lane_enables_n(bus.byte_lane_enables_n),
    .be_oe(bus.be_oe), .address_strobe_n(bus.address_strobe_n),
    .write_cycle(bus.write_cycle), .dev_data(bus.dev_data), .dev_par(bus.dev_par),
    .dev_data_oe(bus.dev_data_oe), .sys_data(bus.sys_data), .sys_par(bus.sys_par),
    .sys_data_oe(bus.sys_data_oe), .ready_n(bus.ready_n), .size_mask(bus.size_mask),
    .parity_check_status_n(bus.parity_check_status_n));
  // ==========
  // helpers
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [3:0] ep(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait, a hang ends the run
  task automatic wait_lv(ref logic s, input logic v);
    for (int i = 0; i < 20 && s !== v; i++) tick();
    if (s !== v) begin
      n_fail++;
      $display("unexpected timeout at %0t: got %0h exp %0h", $time, s, v);
      end_sim();
    end
  endtask
  // one clock request, address taken from data
  task automatic req(input logic b, w, input logic [3:0] be, input logic [31:0] d);
    rw = w;
    rbe = be;
    rwd = d;
    ra = d[29:0];
    if (b) rv2 = 1;
    else rv = 1;
    tick();
    rv = 0;
    rv2 = 0;
  endtask
  // ==========
  // scenarios
  task automatic t_write(input logic [3:0] be, input logic [31:0] d);
    req(0, 1, be, d);
    wait_lv(bus.address_strobe_n, 0);
    `CHK(bus.dev_data_oe, 1'b0)
    `CHK(bus.dev_addr, d[29:0])
    `CHK(bus.byte_lane_enables_n, be)
    tick();
    `CHK(bus.dev_data, d)
    `CHK(bus.dev_par, ep(d))
    wait_lv(wrv, 1);
    `CHK(wrw, d)
    `CHK(wrl, ~be)
    `CHK(wrd, 1'b1)
  endtask
  task automatic t_read(input logic [3:0] be, sz, input logic [31:0] d);
    rdw = d;
    lsm = sz;
    req(0, 0, be, d);
    wait_lv(bus.ready_n, 0);
    `CHK(bus.sys_data, d)
    `CHK(bus.sys_par, ep(d))
    tick();
    `CHK(rdv, 1'b1)
    `CHK(rdd, d)
    `CHK(bus.parity_check_status_n, 1'b1)
    tick();
    `CHK(pes, 1'b0)
  endtask
  // faulty far side flips parity on chosen lanes
  task automatic t_bad(input logic [3:0] be, sz, flip, input logic exp);
    bus2.size_mask = sz;
    req(1, 0, be, 32'h1234ABCD);
    wait_lv(bus2.address_strobe_n, 0);
    tick();
    bus2.sys_data = 32'h1234ABCD;
    bus2.sys_par = ep(32'h1234ABCD) ^ flip;
    bus2.sys_data_oe = 1;
    bus2.ready_n = 0;
    tick();
    bus2.sys_data = ~bus2.sys_data; // released lines show no stale value
    bus2.sys_par = ~bus2.sys_par;
    bus2.sys_data_oe = 0;
    bus2.ready_n = 1;
    `CHK(rdv2, 1'b1)
    `CHK(rdd2, 32'h1234ABCD)
    `CHK(bus2.parity_check_status_n, exp)
    tick();
    `CHK(bus2.parity_check_status_n, 1'b1)
  endtask
  task automatic t_hold();
    bh = 1;
    tick();
    req(0, 1, 4'h0, 32'h5A5A5A5A);
    tick(2);
    `CHK(bus.address_strobe_n, 1'b1)
    `CHK(busy, 1'b1)
    `CHK(bus.addr_oe, 1'b0)
    `CHK(bus.be_oe, 1'b0)
    il = 28'hBEEF123;
    iq = 1;
    tick();
    iq = 0;
    wait_lv(invv, 1);
    `CHK(inva, 28'hBEEF123)
    bh = 0;
    ah = 1;
    tick(2);
    `CHK(bus.addr_oe, 1'b0)
    `CHK(bus.parity_check_status_n, 1'b1)
    `CHK(bus.be_oe, 1'b1)
    ah = 0;
    rst = 1;
    tick(2);
    rst = 0;
    `CHK(bus.byte_lane_enables_n, CBDP_BE_IDLE)
  endtask
  // main sequence
  initial begin
    bus2.sys_data = '0;
    bus2.sys_par = '0;
    bus2.sys_data_oe = 0;
    bus2.ready_n = 1;
    bus2.size_mask = 4'hF;
    bus2.sys_inv_oe = 0;
    bus2.sys_inv_addr = '0;
    tick(4);
    rst = 0;
    t_write(4'h0, 32'hA1B2C3D4);
    t_write(4'hA, 32'h00FF7E81);
    t_read(4'h0, 4'hF, 32'h80402010);
    t_read(4'h6, 4'h3, 32'h7F01FE03);
    t_bad(4'h0, 4'hF, 4'h4, 1'b0);
    t_bad(4'h4, 4'hF, 4'h4, 1'b1);
    t_bad(4'h0, 4'hB, 4'h4, 1'b1);
    t_bad(4'h0, 4'hF, 4'h0, 1'b1);
    t_hold();
    t_write(4'h5, 32'hC0DEF00D);
    end_sim();
  end
endmodule
`default_nettype wire
